/* File: inc/lmc_pkg.sv */
// Constants and types for the laser channel mode and safety controller
package lmc_pkg;

  // ==========================================================================
  // Clocking and timeout
  localparam int unsigned LMC_CLK_FREQ_HZ = 100000000;
  localparam int unsigned LMC_OSC_FREQ_HZ = 200000;
  localparam int unsigned LMC_OSC_DIV = LMC_CLK_FREQ_HZ / LMC_OSC_FREQ_HZ;
  // Least configuration timeout, so it rounds up to whole oscillator ticks
  localparam int unsigned LMC_CFG_TMO_MS = 40;
  localparam int unsigned LMC_CFG_TMO_TICKS = (LMC_CFG_TMO_MS * LMC_OSC_FREQ_HZ + 999) / 1000;

  // ==========================================================================
  // Mode field encoding
  localparam logic [1:0] LMC_MODE_CFG = 2'h2;

  // ==========================================================================
  // Bit positions of the synchronised pin vector
  localparam int unsigned LMC_SYNC_W = 13;
  localparam int unsigned LMC_B_MODE_SEL = 0;
  localparam int unsigned LMC_B_IFACE_SEL = 1;
  localparam int unsigned LMC_B_MODE_OPEN = 2;
  localparam int unsigned LMC_B_SEL_OPEN = 3;
  localparam int unsigned LMC_B_STANDBY_N = 4;
  localparam int unsigned LMC_B_EN_ONE = 5;
  localparam int unsigned LMC_B_EN_TWO = 6;
  localparam int unsigned LMC_B_PD_MAIN = 7;
  localparam int unsigned LMC_B_PD_LOGIC = 9;
  localparam int unsigned LMC_B_OVERTEMP = 10;
  localparam int unsigned LMC_B_OVC = 11;

  // ==========================================================================
  // Reset values
  localparam logic [LMC_SYNC_W-1:0] LMC_SYNC_RST = 13'h0000;
  localparam logic [1:0] LMC_CHAN_RST = 2'h0;

  // ==========================================================================
  // Top-level state
  typedef enum logic [1:0] {
    LMC_ST_STANDBY = 2'b00,
    LMC_ST_RUN     = 2'b01,
    LMC_ST_ERROR   = 2'b10
  } lmc_state_e;

endpackage

/* File: rtl/lmc_pin_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module lmc_pin_sync
  import lmc_pkg::*;
#(
  parameter int unsigned W = LMC_SYNC_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Asynchronous pins and their filtered image
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_d;
  logic [W-1:0] out_q;

  // ==========================================================================
  // Agreement filter
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
    end
  endgenerate

  // ==========================================================================
  // Registers; first stage is read only by the second
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      out_q <= RST_VAL;
    end else if (clk_en) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_out = out_q;

endmodule

/* File: rtl/lmc_safety_ctrl.sv */
// Mode selection and channel safety control for a dual laser driver
`timescale 1ns/10ps
// ============================================================================
// Function
// - A low mode-select pin picks standalone mode and a high one picks microcontroller mode.
// - In microcontroller mode a high interface select pin picks I2C and a low one picks SPI.
// - A floating mode or interface pin outside standby drives the check output low and holds both channels off while it floats.
// - Standalone mode forces both channels to power control with the internal monitor resistors off.
// - In standalone mode the interface pin picks the reference, low for supply-0.25 V, high for supply-0.5 V.
// - Standalone mode fixes the overcurrent limit at its 750 mA maximum and trips only the affected channel.
// - A channel turns on when its enable pin is high and no fault blocks it.
// - While the main or logic supply is powered down the channels are held off.
// - Overcurrent or overtemperature switches channels off and stays latched until enable cycling or power-up.
// - Standby does not clear the held configuration.
// - In microcontroller mode, while the mode field is 10 the time in configuration mode is measured against a 40 to 164 ms limit.
// - When the configuration timeout expires both channels switch off.
// - A channel is off whenever its pin is low or, in microcontroller mode, its disable bit is 1.
module lmc_safety_ctrl
  import lmc_pkg::*;
#(
  parameter int unsigned OSC_DIV = LMC_OSC_DIV,
  parameter int unsigned CFG_TMO_TICKS = LMC_CFG_TMO_TICKS
) (
  // Clock, reset and clock enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Strap pins and their open detectors
  input wire logic host_mode_select_pin,
  input wire logic iface_ref_select_pin,
  input wire logic mode_pin_open_fault,
  input wire logic select_pin_open_fault,
  // Standby and channel enable pins
  input wire logic standby_n,
  input wire logic chan_one_enable_pin,
  input wire logic chan_two_enable_pin,
  // Analog fault detectors
  input wire logic [1:0] main_supply_powerdown,
  input wire logic logic_supply_powerdown,
  input wire logic overtemp_fault,
  input wire logic [1:0] overcurrent_fault,
  // Configuration bits from the register file
  input wire logic [1:0] chan_disable_bit,
  input wire logic [1:0] mode_field,
  // Mode decode
  output logic mcu_mode,
  output logic iface_i2c,
  output logic optical_power_loop_forced,
  output logic programmable_monitor_resistor_off,
  output logic ref_deep_select,
  output logic ilim_force_max,
  // Status and channel control
  output logic fault_indicator_n,
  output logic standby_active,
  output logic cfg_timeout,
  output logic [1:0] shutdown_latched,
  output logic [1:0] chan_on
);

  localparam int unsigned DIV_W = $clog2(OSC_DIV);
  localparam int unsigned TMO_W = $clog2(CFG_TMO_TICKS + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(CFG_TMO_TICKS);

  // ==========================================================================
  // Pin synchronisation
  logic [LMC_SYNC_W-1:0] pins_raw;
  logic [LMC_SYNC_W-1:0] pins;

  assign pins_raw = {overcurrent_fault, overtemp_fault, logic_supply_powerdown, main_supply_powerdown,
                     chan_two_enable_pin, chan_one_enable_pin, standby_n, select_pin_open_fault,
                     mode_pin_open_fault, iface_ref_select_pin, host_mode_select_pin};

  lmc_pin_sync #(
    .W(LMC_SYNC_W),
    .RST_VAL(LMC_SYNC_RST)
  ) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pin_in(pins_raw),
    .pin_out(pins)
  );

  logic mode_sel;
  logic iface_sel;
  logic open_any;
  logic stby_n_s;
  logic [1:0] en_pin;
  logic pd_any;
  logic ot_s;
  logic [1:0] ovc_s;

  assign mode_sel = pins[LMC_B_MODE_SEL];
  assign iface_sel = pins[LMC_B_IFACE_SEL];
  assign open_any = pins[LMC_B_MODE_OPEN] | pins[LMC_B_SEL_OPEN];
  assign stby_n_s = pins[LMC_B_STANDBY_N];
  assign en_pin = {pins[LMC_B_EN_TWO], pins[LMC_B_EN_ONE]};
  assign pd_any = pins[LMC_B_PD_MAIN] | pins[LMC_B_PD_MAIN+1] | pins[LMC_B_PD_LOGIC];
  assign ot_s = pins[LMC_B_OVERTEMP];
  assign ovc_s = pins[LMC_B_OVC+1:LMC_B_OVC];

  // ==========================================================================
  // State
  lmc_state_e state_q;
  lmc_state_e state_d;
  logic mcu_q;
  logic mcu_d;
  logic iface_q;
  logic iface_d;
  logic [1:0] en_prev_q;
  logic [1:0] en_prev_d;
  logic [1:0] latch_q;
  logic [1:0] latch_d;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [TMO_W-1:0] tmo_q;
  logic [TMO_W-1:0] tmo_d;
  logic tmo_hit_q;
  logic tmo_hit_d;
  logic [1:0] chan_q;
  logic [1:0] chan_d;
  logic chk_n_q;
  logic chk_n_d;
  logic i2c_q;
  logic i2c_d;
  logic standalone_q;
  logic standalone_d;
  logic ref_deep_q;
  logic ref_deep_d;
  logic stby_q;
  logic stby_d;

  // ==========================================================================
  // Mode state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      LMC_ST_STANDBY: begin
        if (stby_n_s && open_any) begin
          state_d = LMC_ST_ERROR;
        end else if (stby_n_s) begin
          state_d = LMC_ST_RUN;
        end
      end
      LMC_ST_RUN: begin
        if (!stby_n_s) begin
          state_d = LMC_ST_STANDBY;
        end else if (open_any) begin
          state_d = LMC_ST_ERROR;
        end
      end
      LMC_ST_ERROR: begin
        if (!stby_n_s) begin
          state_d = LMC_ST_STANDBY;
        end else if (!open_any) begin
          state_d = LMC_ST_RUN;
        end
      end
      default: begin
        state_d = LMC_ST_STANDBY;
      end
    endcase
  end

  // ==========================================================================
  // Strap decode, held while in standby so the configuration survives it
  always_comb begin
    mcu_d = mcu_q;
    iface_d = iface_q;
    if (state_q == LMC_ST_RUN) begin
      mcu_d = mode_sel;
      iface_d = iface_sel;
    end
    // Standby leaves the held decode untouched
    if (state_q == LMC_ST_STANDBY) begin
      mcu_d = mcu_q;
      iface_d = iface_q;
    end
  end

  // ==========================================================================
  // Configuration timeout on oscillator ticks
  logic cfg_mode;
  logic osc_tick;

  assign cfg_mode = mcu_q && (mode_field == LMC_MODE_CFG) && (state_q == LMC_ST_RUN);
  assign osc_tick = (div_q == DIV_LAST);

  always_comb begin
    div_d = osc_tick ? '0 : div_q + 1'b1;
    tmo_d = tmo_q;
    tmo_hit_d = tmo_hit_q;
    if (!cfg_mode) begin
      tmo_d = '0;
      tmo_hit_d = 1'b0;
    end else if (osc_tick && !tmo_hit_q) begin
      tmo_d = tmo_q + 1'b1;
      if (tmo_q == TMO_LAST - 1'b1) begin
        tmo_hit_d = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Latched shutdowns and channel gating
  logic [1:0] en_rise;
  logic [1:0] trip;
  logic [1:0] allow;

  assign en_rise = en_pin & ~en_prev_q;

  always_comb begin
    en_prev_d = en_pin;
    // Standalone trips only the channel that saw overcurrent; host mode drops both
    if (!mcu_q) begin
      trip = ovc_s;
    end else begin
      trip = {2{|ovc_s}};
    end
    trip = trip | {2{ot_s}};
    trip = trip | {2{tmo_hit_d & ~tmo_hit_q}};
    // A trip in the same cycle as an enable edge still latches
    latch_d = (latch_q & ~en_rise) | trip;
    allow = en_pin & ~latch_d;
    if (mcu_q) begin
      allow = allow & ~chan_disable_bit;
    end
    if (tmo_hit_d) begin
      allow = 2'h0;
    end
    if (pd_any) begin
      allow = 2'h0;
    end
    if (state_q != LMC_ST_RUN || state_d != LMC_ST_RUN) begin
      allow = 2'h0;
    end
    chan_d = allow;
    chk_n_d = !(open_any && stby_n_s);
  end

  // ==========================================================================
  // Output decode, built from next values so the pins leave flops with no extra lag
  always_comb begin
    i2c_d = mcu_d & iface_d;
    standalone_d = ~mcu_d;
    ref_deep_d = ~mcu_d & iface_d;
    stby_d = (state_d == LMC_ST_STANDBY);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= LMC_ST_STANDBY;
      mcu_q <= 1'b0;
      iface_q <= 1'b0;
      en_prev_q <= LMC_CHAN_RST;
      latch_q <= LMC_CHAN_RST;
      div_q <= '0;
      tmo_q <= '0;
      tmo_hit_q <= 1'b0;
      chan_q <= LMC_CHAN_RST;
      chk_n_q <= 1'b1;
      i2c_q <= 1'b0;
      standalone_q <= 1'b1;
      ref_deep_q <= 1'b0;
      stby_q <= 1'b1;
    end else if (clk_en) begin
      state_q <= state_d;
      mcu_q <= mcu_d;
      iface_q <= iface_d;
      en_prev_q <= en_prev_d;
      latch_q <= latch_d;
      div_q <= div_d;
      tmo_q <= tmo_d;
      tmo_hit_q <= tmo_hit_d;
      chan_q <= chan_d;
      chk_n_q <= chk_n_d;
      i2c_q <= i2c_d;
      standalone_q <= standalone_d;
      ref_deep_q <= ref_deep_d;
      stby_q <= stby_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops
  assign mcu_mode = mcu_q;
  assign iface_i2c = i2c_q;
  assign optical_power_loop_forced = standalone_q;
  assign programmable_monitor_resistor_off = standalone_q;
  assign ref_deep_select = ref_deep_q;
  assign ilim_force_max = standalone_q;
  assign fault_indicator_n = chk_n_q;
  assign standby_active = stby_q;
  assign cfg_timeout = tmo_hit_q;
  assign shutdown_latched = latch_q;
  assign chan_on = chan_q;

endmodule

/* File: test/lmc_safety_ctrl_checker.sv */
// Port assertions for the safety controller
`timescale 1ns/10ps
module lmc_safety_ctrl_checker (
  // Clock, reset and pins
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic chan_one_enable_pin,
  input wire logic logic_supply_powerdown,
  input wire logic [1:0] chan_disable_bit,
  // Decode and channel outputs
  input wire logic mcu_mode,
  input wire logic iface_i2c,
  input wire logic optical_power_loop_forced,
  input wire logic programmable_monitor_resistor_off,
  input wire logic ref_deep_select,
  input wire logic ilim_force_max,
  input wire logic fault_indicator_n,
  input wire logic standby_active,
  input wire logic cfg_timeout,
  input wire logic [1:0] shutdown_latched,
  input wire logic [1:0] chan_on
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // Pin repetition counts cover the four-edge synchroniser and the channel flop plus one margin
  a_standalone_dec: assert property (!mcu_mode |-> ilim_force_max && optical_power_loop_forced
    && programmable_monitor_resistor_off) else $error("standalone decode wrong");
  a_ref_standalone: assert property (ref_deep_select |-> !mcu_mode) else $error("reference select in mcu mode");
  a_i2c_mcu_only: assert property (iface_i2c |-> mcu_mode) else $error("protocol select outside mcu mode");
  a_pin_low_off: assert property (!chan_one_enable_pin [*7] |-> !chan_on[0]) else $error("channel on with pin low");
  a_open_blocks: assert property (!fault_indicator_n |-> chan_on == 2'h0) else $error("channel on in error");
  a_latch_off: assert property (shutdown_latched[0] |-> !chan_on[0]) else $error("channel on while latched");
  a_pdown_off: assert property (logic_supply_powerdown [*7] |-> chan_on == 2'h0) else $error("on in powerdown");
  a_tmo_off: assert property (cfg_timeout |-> chan_on == 2'h0) else $error("on after timeout");
  a_standby_off: assert property (standby_active |-> chan_on == 2'h0) else $error("channel on in standby");
  a_disable_off: assert property ((mcu_mode && chan_disable_bit[0]) [*3] |-> !chan_on[0])
    else $error("disable bit ignored");
endmodule

/* File: test/lmc_far_model.sv */
// Far side model: laser loops that report an injected overcurrent
`timescale 1ns/10ps
module lmc_far_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Loop drive and injected short
  input wire logic [1:0] chan_on,
  input wire logic [1:0] ovc_req,
  output logic [1:0] overcurrent_fault
);
  logic [1:0] ovc_d;
  // A loop draws current, and so can trip, only while its channel is on
  always_comb begin
    ovc_d = ovc_req & chan_on;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overcurrent_fault <= 2'h0;
    end else begin
      overcurrent_fault <= ovc_d;
    end
  end
endmodule

/* File: test/tb_lmc_safety_ctrl.sv */
// Self-checking bench for the safety controller
`timescale 1ns/10ps
module tb_lmc_safety_ctrl;
  import lmc_pkg::*;
  logic ref_clk, arst_n, clk_en, host_mode_select_pin, iface_ref_select_pin, mode_pin_open_fault;
  logic select_pin_open_fault, standby_n, chan_one_enable_pin, chan_two_enable_pin, logic_supply_powerdown;
  logic overtemp_fault, mcu_mode, iface_i2c, optical_power_loop_forced, programmable_monitor_resistor_off;
  logic ref_deep_select, ilim_force_max, fault_indicator_n, standby_active, cfg_timeout;
  logic [1:0] main_supply_powerdown, overcurrent_fault, chan_disable_bit, mode_field, shutdown_latched;
  logic [1:0] chan_on, ovc_req;
  int fail_count, checked, cyc;
  // Short divider and tick count keep the timeout run brief
  localparam int unsigned TB_DIV = 4;
  localparam int unsigned TB_TICKS = 5;
  lmc_safety_ctrl #(.OSC_DIV(TB_DIV), .CFG_TMO_TICKS(TB_TICKS)) u_lmc_safety_ctrl (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .host_mode_select_pin(host_mode_select_pin), .iface_ref_select_pin(iface_ref_select_pin),
    .mode_pin_open_fault(mode_pin_open_fault), .select_pin_open_fault(select_pin_open_fault),
    .standby_n(standby_n), .chan_one_enable_pin(chan_one_enable_pin),
    .chan_two_enable_pin(chan_two_enable_pin), .main_supply_powerdown(main_supply_powerdown),
    .logic_supply_powerdown(logic_supply_powerdown), .overtemp_fault(overtemp_fault),
    .overcurrent_fault(overcurrent_fault), .chan_disable_bit(chan_disable_bit), .mode_field(mode_field),
    .mcu_mode(mcu_mode), .iface_i2c(iface_i2c), .optical_power_loop_forced(optical_power_loop_forced),
    .programmable_monitor_resistor_off(programmable_monitor_resistor_off),
    .ref_deep_select(ref_deep_select), .ilim_force_max(ilim_force_max),
    .fault_indicator_n(fault_indicator_n), .standby_active(standby_active),
    .cfg_timeout(cfg_timeout), .shutdown_latched(shutdown_latched), .chan_on(chan_on)
  );
  lmc_far_model u_lmc_far_model (
    .ref_clk(ref_clk), .arst_n(arst_n), .chan_on(chan_on), .ovc_req(ovc_req),
    .overcurrent_fault(overcurrent_fault)
  );
  always #5 ref_clk = ~ref_clk;
  // ==========================================================================
  // Helpers
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cycle_pins;
    {chan_one_enable_pin, chan_two_enable_pin} = 2'h0;
    w(8);
    {chan_one_enable_pin, chan_two_enable_pin} = 2'h3;
    w(8);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_standalone;
    standby_n = 1'b1;
    iface_ref_select_pin = 1'b1;
    {chan_one_enable_pin, chan_two_enable_pin} = 2'h3;
    w(10);
    chk("mode ref", 2'h1, {mcu_mode, ref_deep_select});
    chk("loop limit", 2'h3, {ilim_force_max, optical_power_loop_forced});
    chk("chan_on", 2'h3, chan_on);
    iface_ref_select_pin = 1'b0;
    w(8);
    chk("ref low", 2'h0, {1'b0, ref_deep_select});
    ovc_req = 2'h1;
    w(8);
    chk("latched", 2'h1, shutdown_latched);
    chk("ovc chan_on", 2'h2, chan_on);
    ovc_req = 2'h0;
    w(8);
    chk("held off", 2'h2, chan_on);
    cycle_pins();
    chk("rearmed", 2'h3, chan_on);
    $display("standalone test done");
  endtask
  task automatic t_supply;
    logic_supply_powerdown = 1'b1;
    w(8);
    chk("logic pd", 2'h0, chan_on);
    logic_supply_powerdown = 1'b0;
    main_supply_powerdown = 2'h2;
    w(8);
    chk("main pd", 2'h0, chan_on);
    chk("no latch", 2'h0, shutdown_latched);
    main_supply_powerdown = 2'h0;
    w(8);
    chk("pd back", 2'h3, chan_on);
    select_pin_open_fault = 1'b1;
    w(8);
    chk("open flag", 2'h0, {1'b0, fault_indicator_n});
    chk("open off", 2'h0, chan_on);
    select_pin_open_fault = 1'b0;
    w(8);
    chk("open gone", 2'h1, {1'b0, fault_indicator_n});
    mode_pin_open_fault = 1'b1;
    w(8);
    chk("mode open flag", 2'h0, {1'b0, fault_indicator_n});
    chk("mode open off", 2'h0, chan_on);
    mode_pin_open_fault = 1'b0;
    w(8);
    chk("mode open gone", 2'h3, chan_on);
    $display("supply and strap test done");
  endtask
  task automatic t_mcu;
    host_mode_select_pin = 1'b1;
    iface_ref_select_pin = 1'b1;
    w(8);
    chk("mcu i2c", 2'h3, {mcu_mode, iface_i2c});
    chk("mcu free", 2'h0, {ilim_force_max, programmable_monitor_resistor_off});
    iface_ref_select_pin = 1'b0;
    chan_disable_bit = 2'h1;
    w(8);
    chk("spi", 2'h0, {1'b0, iface_i2c});
    chk("disabled", 2'h2, chan_on);
    chan_disable_bit = 2'h0;
    overtemp_fault = 1'b1;
    w(8);
    chk("ot latch", 2'h3, shutdown_latched);
    chk("ot off", 2'h0, chan_on);
    overtemp_fault = 1'b0;
    cycle_pins();
    chk("ot rearm", 2'h3, chan_on);
    $display("mcu test done");
  endtask
  task automatic t_cfg_standby;
    mode_field = LMC_MODE_CFG;
    w(TB_DIV * (TB_TICKS - 1));
    chk("tmo early", 2'h0, {1'b0, cfg_timeout});
    w(TB_DIV);
    chk("tmo", 2'h1, {1'b0, cfg_timeout});
    chk("tmo off", 2'h0, chan_on);
    mode_field = 2'h0;
    w(2);
    chk("tmo clear", 2'h0, {1'b0, cfg_timeout});
    standby_n = 1'b0;
    w(8);
    chk("standby", 2'h1, {1'b0, standby_active});
    host_mode_select_pin = 1'b0;
    w(8);
    chk("kept", 2'h1, {1'b0, mcu_mode});
    host_mode_select_pin = 1'b1;
    standby_n = 1'b1;
    w(8);
    chk("woken", 2'h0, {1'b0, standby_active});
    $display("config and standby test done");
  endtask
  // ==========================================================================
  // Main sequence and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    {ref_clk, arst_n, host_mode_select_pin, iface_ref_select_pin, mode_pin_open_fault} = 5'h0;
    {select_pin_open_fault, standby_n, chan_one_enable_pin, chan_two_enable_pin} = 4'h0;
    {logic_supply_powerdown, overtemp_fault, main_supply_powerdown, chan_disable_bit} = 6'h0;
    {mode_field, ovc_req} = 4'h0;
    clk_en = 1'b1;
    w(12);
    chk("reset off", 2'h0, chan_on);
    chk("reset standby", 2'h1, {1'b0, standby_active});
    $display("reset test done");
    arst_n = 1'b1;
    t_standalone();
    t_supply();
    t_mcu();
    t_cfg_standby();
    report_and_stop();
  end
endmodule
bind lmc_safety_ctrl lmc_safety_ctrl_checker u_lmc_safety_ctrl_checker (
  .ref_clk(ref_clk), .arst_n(arst_n), .chan_one_enable_pin(chan_one_enable_pin),
  .logic_supply_powerdown(logic_supply_powerdown), .chan_disable_bit(chan_disable_bit), .mcu_mode(mcu_mode),
  .iface_i2c(iface_i2c), .optical_power_loop_forced(optical_power_loop_forced),
  .programmable_monitor_resistor_off(programmable_monitor_resistor_off), .ref_deep_select(ref_deep_select),
  .ilim_force_max(ilim_force_max), .fault_indicator_n(fault_indicator_n), .standby_active(standby_active),
  .cfg_timeout(cfg_timeout), .shutdown_latched(shutdown_latched), .chan_on(chan_on)
);
